// *** verilog/ccrb_pkg.sv ***
// Package for the converter configuration register bank.
// Assumes a word-addressed 16-bit register port.
package ccrb_pkg;

    // ****************************************
    // Register offsets (word addresses)
    // ****************************************
    localparam logic [5:0] PORT_CFG0_OFS     = 6'h01;
    localparam logic [5:0] PORT_CFG1_OFS     = 6'h02;
    localparam logic [5:0] MISC_WORD0_OFS    = 6'h03;
    localparam logic [5:0] MISC_WORD1_OFS    = 6'h04;
    localparam logic [5:0] MISC_WORD2_OFS    = 6'h05;
    localparam logic [5:0] BUF_WORD0_OFS     = 6'h06;
    localparam logic [5:0] BUF_WORD1_OFS     = 6'h07;
    localparam logic [5:0] BUF_WORD2_OFS     = 6'h08;
    localparam logic [5:0] P0_IN_LIMIT_OFS   = 6'h09;
    localparam logic [5:0] P0_OUT_LIMIT_OFS  = 6'h0a;
    localparam logic [5:0] P1_IN_LIMIT_OFS   = 6'h0b;
    localparam logic [5:0] P1_OUT_LIMIT_OFS  = 6'h0c;
    localparam logic [5:0] PHY_RSVD_OFS      = 6'h0d;
    localparam logic [5:0] STRAP_STAT_OFS    = 6'h3e;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] PORT_CFG_RST     = 16'h104f;
    localparam logic [15:0] MISC_WORD0_RST   = 16'h0600;
    localparam logic [15:0] MISC_WORD1_RST   = 16'h0000;
    localparam logic [15:0] MISC_WORD2_RST   = 16'h0014;
    localparam logic [15:0] BUF_WORD0_RST    = 16'h0198;
    localparam logic [15:0] BUF_WORD1_RST    = 16'h0258;
    localparam logic [15:0] BUF_WORD2_RST    = 16'h0008;
    localparam logic [15:0] LIMIT_RST        = 16'h0000;
    localparam logic [15:0] PHY_RSVD_RST     = 16'h1a74;

    // Writable masks: reserved bits stay zero
    localparam logic [15:0] MISC_WORD1_WMASK = 16'hf7e0;
    localparam logic [15:0] MISC_WORD2_WMASK = 16'hffbf;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int ADV_ALL_BIT    = 4;
    localparam int DUPLEX_BIT     = 3;
    localparam int SPEED_BIT      = 2;
    localparam int AUTONEG_BIT    = 1;
    localparam int PAUSE_BIT      = 0;
    localparam int CRC_OFF_BIT    = 15;
    localparam int CRS_OFF_BIT    = 14;
    localparam int MAXLEN_MSB     = 13;
    localparam logic [13:0] MAX_FRAME_CEIL = 14'h2400;
    localparam int LED_MODE_BIT   = 15;
    localparam int LED_TEST_BIT   = 14;
    localparam int HASH_CRC_BIT   = 13;
    localparam int PAUSE_POL_BIT  = 12;
    localparam int VLAN_REPL_BIT  = 10;
    localparam int EMU_FORCE_BIT  = 9;
    localparam int PREAMBLE_BIT   = 8;
    localparam int BACKOFF_BIT    = 7;
    localparam int DROP16_BIT     = 6;
    localparam int AGING_OFF_BIT  = 5;
    localparam int IRQ_POL_BIT    = 15;
    localparam int FAST_AGE_BIT   = 14;
    localparam int STRAP_INV_MSB  = 13;
    localparam int STRAP_INV_LSB  = 7;
    localparam int FAULT_MSB      = 5;
    localparam int FAULT_LSB      = 4;
    localparam int FPROP_OFF_BIT  = 3;
    localparam int SNOOP_OFF_BIT  = 2;
    localparam int LB_LED_BIT     = 1;
    localparam int LB_LINK_BIT    = 0;
    localparam int LIMIT_EN_BIT   = 15;

    // Fault reporting method encoding
    localparam logic [1:0] FAULT_OAM  = 2'h0;
    localparam logic [1:0] FAULT_FEFI = 2'h1;

endpackage

// *** verilog/ccrb_top.sv ***
// Configuration register bank of a two-port fiber-to-copper converter.
// Assumes a same-clock register master: one-cycle strobes, read data
// the cycle after, and strap pins arriving asynchronously.
// Notes on behaviour
// - Port word bit 4 set advertises all four abilities, else follows settings.
// - Port word bit 3 picks duplex; 1 full, default full.
// - Port word bit 2 picks forced speed; 1 is 100M, default.
// - Port word bit 1 enables autonegotiation, default on; off uses forced mode.
// - Port word bit 0 enables pause ability, default on.
// - Misc0 bit 15 set turns frame CRC checking off.
// - Misc0 bit 14 set turns the carrier length check off.
// - Misc0 bits 13:0 give max frame bytes, default 1536, ceiling 9216.
// - Misc1 bit 15 picks copper LED behaviour while link is down.
// - Misc1 bit 14 lights all LEDs together during self test.
// - Misc1 bit 13 picks CRC hash instead of direct address bits.
// - Misc1 bit 12 keeps sending on pause when forced and pause off.
// - Misc1 bit 10 replaces received VLAN IDs 0 and 1 by default.
// - Misc1 bit 8 picks six preamble bytes instead of seven.
// - Misc1 bit 7 disables back-off; bit 6 drops after sixteen collisions.
// - Misc1 bit 5 disables aging; misc2 bit 14 selects fast aging.
// - Misc2 bit 15 picks interrupt pin level; default active low.
// - Misc2 bits 13 to 7 invert seven strap groups when set.
// - Misc2 bits 5:4 pick fault reporting: OAM, FEFI default, or off.
// - Misc2 bit 3 disables fault propagation; bit 2 disables snooping.
// - Misc2 bits 1 and 0 set copper LED and link during loopback.
// - Each port has ingress and egress limit words: enable and threshold.
// - Every register is one whole 16-bit word at one address.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

module ccrb_top
    import ccrb_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // Clock, reset and enable
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // Strap pins, seven groups, raw
    input  wire logic [6:0]        strap_pins,
    // Internal event to present on the interrupt pin
    input  wire logic              irq_event,
    // Per-port link settings
    output logic      [1:0]        advert_all_abilities,
    output logic      [1:0]        duplex_select,
    output logic      [1:0]        speed_select,
    output logic      [1:0]        autoneg_enable,
    output logic      [1:0]        pause_ability_enable,
    // Frame checking
    output logic                   crc_check_off,
    output logic                   carrier_length_check_off,
    output logic      [13:0]       max_frame_bytes,
    // Switch behaviour
    output logic                   linkdown_led_mode,
    output logic                   led_test_all_on,
    output logic                   hash_use_crc,
    output logic                   pause_rx_stop_policy,
    output logic                   vlan_id_replace,
    output logic                   emulated_force_port0,
    output logic                   preamble_length_select,
    output logic                   backoff_off,
    output logic                   drop_after_collisions,
    output logic                   aging_off,
    output logic                   fast_aging,
    // Pins and converter mode
    output logic                   irq_pin,
    output logic      [6:0]        strap_effective,
    output logic      [1:0]        fault_report_method,
    output logic                   fault_propagate_off,
    output logic                   snoop_off,
    output logic                   copper_led_in_loopback,
    output logic                   copper_link_in_loopback,
    // Bandwidth limits, index 0 port0, 1 port1
    output logic      [1:0]        in_limit_en,
    output logic      [29:0]       in_limit_thresh,
    output logic      [1:0]        out_limit_en,
    output logic      [29:0]       out_limit_thresh
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [1:0][15:0] port_cfg;
        logic [15:0]      misc0;
        logic [15:0]      misc1;
        logic [15:0]      misc2;
        logic [1:0][15:0] in_lim;
        logic [1:0][15:0] out_lim;
        logic [6:0]       strap_s1;
        logic [6:0]       strap_s2;
        logic [15:0]      rdata;
        logic             irq;
        logic [6:0]       strap_eff;
    } ccrb_state_t;

    ccrb_state_t state_ff;
    ccrb_state_t nxt_state;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic [15:0] rd;
        logic [13:0] len;
        rd  = 16'h0000;
        len = reg_wdata[MAXLEN_MSB:0];
        nxt_state = state_ff;
        // Two-flop synchroniser; only the second stage feeds logic
        nxt_state.strap_s1 = strap_pins;
        nxt_state.strap_s2 = state_ff.strap_s1;
        nxt_state.strap_eff = state_ff.strap_s2 ^
            state_ff.misc2[STRAP_INV_MSB:STRAP_INV_LSB];
        nxt_state.irq = state_ff.misc2[IRQ_POL_BIT] ?
            irq_event : ~irq_event;
        // Whole-word writes only; no byte lanes exist
        if (reg_wr) begin
            unique case (reg_addr)
                PORT_CFG0_OFS: nxt_state.port_cfg[0] = reg_wdata;
                PORT_CFG1_OFS: nxt_state.port_cfg[1] = reg_wdata;
                MISC_WORD0_OFS: begin
                    // Clamp to the ceiling so oversize logic never sees more
                    if (len > MAX_FRAME_CEIL) begin
                        len = MAX_FRAME_CEIL;
                    end
                    nxt_state.misc0 = {reg_wdata[15:14], len};
                end
                MISC_WORD1_OFS:
                    nxt_state.misc1 = reg_wdata & MISC_WORD1_WMASK;
                MISC_WORD2_OFS:
                    nxt_state.misc2 = reg_wdata & MISC_WORD2_WMASK;
                P0_IN_LIMIT_OFS:  nxt_state.in_lim[0]  = reg_wdata;
                P0_OUT_LIMIT_OFS: nxt_state.out_lim[0] = reg_wdata;
                P1_IN_LIMIT_OFS:  nxt_state.in_lim[1]  = reg_wdata;
                P1_OUT_LIMIT_OFS: nxt_state.out_lim[1] = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                PORT_CFG0_OFS:    rd = state_ff.port_cfg[0];
                PORT_CFG1_OFS:    rd = state_ff.port_cfg[1];
                MISC_WORD0_OFS:   rd = state_ff.misc0;
                MISC_WORD1_OFS:   rd = state_ff.misc1;
                MISC_WORD2_OFS:   rd = state_ff.misc2;
                BUF_WORD0_OFS:    rd = BUF_WORD0_RST;
                BUF_WORD1_OFS:    rd = BUF_WORD1_RST;
                BUF_WORD2_OFS:    rd = BUF_WORD2_RST;
                P0_IN_LIMIT_OFS:  rd = state_ff.in_lim[0];
                P0_OUT_LIMIT_OFS: rd = state_ff.out_lim[0];
                P1_IN_LIMIT_OFS:  rd = state_ff.in_lim[1];
                P1_OUT_LIMIT_OFS: rd = state_ff.out_lim[1];
                PHY_RSVD_OFS:     rd = PHY_RSVD_RST;
                STRAP_STAT_OFS:   rd = {9'h000, state_ff.strap_eff};
                default:          rd = 16'h0000;
            endcase
        end
        nxt_state.rdata = rd;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff.port_cfg  <= {PORT_CFG_RST, PORT_CFG_RST};
            state_ff.misc0     <= MISC_WORD0_RST;
            state_ff.misc1     <= MISC_WORD1_RST;
            state_ff.misc2     <= MISC_WORD2_RST;
            state_ff.in_lim    <= {LIMIT_RST, LIMIT_RST};
            state_ff.out_lim   <= {LIMIT_RST, LIMIT_RST};
            state_ff.strap_s1  <= 7'h00;
            state_ff.strap_s2  <= 7'h00;
            state_ff.rdata     <= 16'h0000;
            // Interrupt idles inactive at the default low-active level
            state_ff.irq       <= 1'b1;
            state_ff.strap_eff <= 7'h00;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Outputs, all straight from flops
    // ****************************************
    for (genvar p = 0; p < 2; p++) begin : g_port
        assign advert_all_abilities[p] =
            state_ff.port_cfg[p][ADV_ALL_BIT];
        assign duplex_select[p] =
            state_ff.port_cfg[p][DUPLEX_BIT];
        assign speed_select[p] =
            state_ff.port_cfg[p][SPEED_BIT];
        assign autoneg_enable[p] =
            state_ff.port_cfg[p][AUTONEG_BIT];
        assign pause_ability_enable[p] =
            state_ff.port_cfg[p][PAUSE_BIT];
        assign in_limit_en[p] =
            state_ff.in_lim[p][LIMIT_EN_BIT];
        assign in_limit_thresh[p*15 +: 15] =
            state_ff.in_lim[p][14:0];
        assign out_limit_en[p] = state_ff.out_lim[p][LIMIT_EN_BIT];
        assign out_limit_thresh[p*15 +: 15] = state_ff.out_lim[p][14:0];
    end

    assign crc_check_off            = state_ff.misc0[CRC_OFF_BIT];
    assign carrier_length_check_off = state_ff.misc0[CRS_OFF_BIT];
    assign max_frame_bytes          = state_ff.misc0[MAXLEN_MSB:0];
    assign linkdown_led_mode        = state_ff.misc1[LED_MODE_BIT];
    assign led_test_all_on          = state_ff.misc1[LED_TEST_BIT];
    assign hash_use_crc             = state_ff.misc1[HASH_CRC_BIT];
    assign pause_rx_stop_policy     = state_ff.misc1[PAUSE_POL_BIT];
    assign vlan_id_replace          = state_ff.misc1[VLAN_REPL_BIT];
    assign emulated_force_port0     = state_ff.misc1[EMU_FORCE_BIT];
    assign preamble_length_select   = state_ff.misc1[PREAMBLE_BIT];
    assign backoff_off              = state_ff.misc1[BACKOFF_BIT];
    assign drop_after_collisions    = state_ff.misc1[DROP16_BIT];
    assign aging_off                = state_ff.misc1[AGING_OFF_BIT];
    assign fast_aging               = state_ff.misc2[FAST_AGE_BIT];
    assign irq_pin                  = state_ff.irq;
    assign strap_effective          = state_ff.strap_eff;
    assign fault_report_method      =
        state_ff.misc2[FAULT_MSB:FAULT_LSB];
    assign fault_propagate_off      = state_ff.misc2[FPROP_OFF_BIT];
    assign snoop_off                = state_ff.misc2[SNOOP_OFF_BIT];
    assign copper_led_in_loopback   = state_ff.misc2[LB_LED_BIT];
    assign copper_link_in_loopback  = state_ff.misc2[LB_LINK_BIT];
    assign reg_rdata                = state_ff.rdata;

endmodule

// *** tb/ccrb_top_asserts.sv ***
// Checker bound to the register bank top module.
// Assumes one clock domain; sees only the top module's ports.
`timescale 1ns/1ps

module ccrb_asserts
    import ccrb_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // Clock, reset and register port
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic              clk_en,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0]       reg_wdata,
    input wire logic [15:0]       reg_rdata,
    // Pins
    input wire logic [6:0]        strap_pins,
    input wire logic [6:0]        strap_effective,
    input wire logic              irq_event,
    input wire logic              irq_pin,
    // Settings
    input wire logic [1:0]        advert_all_abilities,
    input wire logic [1:0]        duplex_select,
    input wire logic [1:0]        speed_select,
    input wire logic [1:0]        autoneg_enable,
    input wire logic [1:0]        pause_ability_enable,
    input wire logic [1:0]        fault_report_method,
    input wire logic [13:0]       max_frame_bytes,
    input wire logic              fault_propagate_off,
    input wire logic              snoop_off,
    input wire logic [1:0]        out_limit_en,
    input wire logic [29:0]       out_limit_thresh
);
    // ****************************************
    // Shadow of the pin controls
    // ****************************************
    logic       pol_ff;
    logic [6:0] inv_ff;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pol_ff <= 1'b0;
            inv_ff <= 7'h00;
        end else if (clk_en && reg_wr && reg_addr == MISC_WORD2_OFS) begin
            pol_ff <= reg_wdata[IRQ_POL_BIT];
            inv_ff <= reg_wdata[STRAP_INV_MSB:STRAP_INV_LSB];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_rdata_idle_zero: assert property (
        clk_en && !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_maxlen_read: assert property (
        clk_en && reg_rd && reg_addr == MISC_WORD0_OFS
        |=> reg_rdata[13:0] == $past(max_frame_bytes))
        else $error("frame length read back differs from output");
    a_maxlen_clamp: assert property (
        clk_en && reg_wr && reg_addr == MISC_WORD0_OFS
        && reg_wdata[13:0] > MAX_FRAME_CEIL
        |=> max_frame_bytes == MAX_FRAME_CEIL)
        else $error("oversize frame length not held at ceiling");
    a_port0_fields: assert property (
        clk_en && reg_wr && reg_addr == PORT_CFG0_OFS
        |=> {advert_all_abilities[0], duplex_select[0], speed_select[0],
        autoneg_enable[0], pause_ability_enable[0]} == $past(reg_wdata[4:0]))
        else $error("port 0 link settings differ from written word");
    a_reset_values: assert property (
        $rose(rstn) |-> fault_report_method == FAULT_FEFI && snoop_off
        && !fault_propagate_off && speed_select == 2'h3
        && duplex_select == 2'h3 && advert_all_abilities == 2'h0)
        else $error("settings after reset differ from defaults");
    a_fault_write: assert property (
        clk_en && reg_wr && reg_addr == MISC_WORD2_OFS
        |=> {fault_report_method, fault_propagate_off, snoop_off}
        == $past(reg_wdata[5:2]))
        else $error("fault controls differ from written word");
    a_irq_level: assert property (
        rstn && clk_en |=> irq_pin == ($past(irq_event) ~^ $past(pol_ff)))
        else $error("interrupt pin level ignores polarity");
    a_strap_invert: assert property (
        clk_en [*4] |=> strap_effective
        == ($past(strap_pins, 3) ^ $past(inv_ff)))
        else $error("strap levels not inverted as configured");
    a_limit_write: assert property (
        clk_en && reg_wr && reg_addr == P1_OUT_LIMIT_OFS
        |=> {out_limit_en[1], out_limit_thresh[29:15]} == $past(reg_wdata))
        else $error("port 1 egress limit differs from written word");

    c_clamp: cover property (reg_wr && max_frame_bytes == MAX_FRAME_CEIL);
    c_fault_off: cover property (fault_report_method == 2'h3);
    c_strap_inv: cover property (inv_ff == 7'h7f);
endmodule

bind ccrb_top ccrb_asserts #(.ADDR_W(ADDR_W)) u_ccrb_asserts (.*);

// *** tb/ccrb_bench.sv ***
// Bench for the register bank: register walks and pin checks.
// Assumes the checker file binds itself to the top module.
`timescale 1ns/1ps

module ccrb_bench
    import ccrb_pkg::*;
;
    logic        sys_clk, rstn, clk_en, reg_wr, reg_rd, irq_event, irq_pin;
    logic        crc_check_off, carrier_length_check_off, linkdown_led_mode;
    logic        led_test_all_on, hash_use_crc, pause_rx_stop_policy;
    logic        vlan_id_replace, emulated_force_port0, preamble_length_select;
    logic        backoff_off, drop_after_collisions, aging_off, fast_aging;
    logic        fault_propagate_off, snoop_off, copper_led_in_loopback;
    logic        copper_link_in_loopback, b;
    logic [5:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [6:0]  strap_pins, strap_effective;
    logic [13:0] max_frame_bytes;
    logic [1:0]  advert_all_abilities, duplex_select, speed_select;
    logic [1:0]  autoneg_enable, pause_ability_enable, fault_report_method;
    logic [1:0]  in_limit_en, out_limit_en;
    logic [29:0] in_limit_thresh, out_limit_thresh;
    int          n_mismatch, tests_run;
    logic        rd_seen_ff;
    logic [15:0] rd_exp, exp_ff;
    logic [15:0] rst_tab [14] = '{16'h104f, 16'h104f, 16'h0600, 16'h0000,
        16'h0014, 16'h0198, 16'h0258, 16'h0008, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h1a74, 16'h0000};
    logic [15:0] msk_tab [14] = '{16'hffff, 16'hffff, 16'hffff, 16'hf7e0,
        16'hffbf, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'hffff,
        16'hffff, 16'hffff, 16'h0000, 16'h0000};
    logic [15:0] pats [6] = '{16'hffff, 16'h2401, 16'h2400, 16'ha5a5,
        16'h5a5a, 16'h0000};

    ccrb_top dut (.*);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Bus tasks; every change lands by NBA on a rising edge
    // ****************************************
    function automatic logic [5:0] addr_of(int k);
        return (k == 13) ? 6'h20 : 6'(k + 1);
    endfunction

    // Read-only and unmapped words keep their constant
    function automatic logic [15:0] expect_of(int k, logic [15:0] d);
        logic [15:0] e;
        e = (d & msk_tab[k]) | (rst_tab[k] & ~msk_tab[k]);
        if (k == 2 && d[13:0] > 14'h2400) e[13:0] = 14'h2400;
        return e;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
    endtask

    // The read is taken at the edge where the task returns; its data
    // stand only in the cycle after, so the compare waits one more edge
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_exp <= e;
        @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        if (rd_seen_ff) begin
            chk(reg_rdata, exp_ff);
        end
        rd_seen_ff <= reg_rd && clk_en && rstn;
        exp_ff <= rd_exp;
    end

    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic do_reset();
        // Let a read in flight be compared before the bank clears
        idle(1);
        rstn <= 1'b0;
        idle(6);
        rstn <= 1'b1;
        idle(1);
        for (int k = 0; k < 14; k++) rd(addr_of(k), rst_tab[k]);
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        {rstn, reg_wr, reg_rd, irq_event, reg_addr, reg_wdata} = '0;
        {n_mismatch, tests_run, strap_pins} = '0;
        clk_en = 1'b1;
        @(posedge sys_clk);
        do_reset();
        for (int p = 0; p < 6; p++) begin
            for (int k = 0; k < 14; k++) begin
                wr(addr_of(k), pats[p]);
                rd(addr_of(k), expect_of(k, pats[p]));
            end
            if (p == 0 || p == 5) begin
                b = pats[p][0];
                chk({linkdown_led_mode, led_test_all_on, hash_use_crc,
                    pause_rx_stop_policy, vlan_id_replace, emulated_force_port0,
                    preamble_length_select, backoff_off, drop_after_collisions,
                    aging_off, fast_aging}, {11{b}});
                chk({in_limit_en, in_limit_thresh}, {32{b}});
                chk({out_limit_en, out_limit_thresh}, {32{b}});
                chk({crc_check_off, carrier_length_check_off},
                    {2{b}});
                chk(max_frame_bytes, b ? MAX_FRAME_CEIL : 14'h0000);
                chk({fault_propagate_off, snoop_off,
                    copper_led_in_loopback, copper_link_in_loopback}, {4{b}});
                chk(strap_effective, {7{b}});
                chk(irq_pin, !b);
            end
        end
        for (int c = 0; c < 4; c++) begin
            wr(MISC_WORD2_OFS, 16'(c) << 4);
            idle(1);
            chk(fault_report_method, c[1:0]);
        end
        strap_pins <= 7'h55;
        irq_event <= 1'b1;
        wr(MISC_WORD2_OFS, 16'h0000);
        idle(4);
        chk({strap_effective, irq_pin}, 8'haa);
        wr(MISC_WORD2_OFS, 16'hbf80);
        idle(4);
        chk({strap_effective, irq_pin}, 8'h55);
        rd(STRAP_STAT_OFS, 16'h002a);
        wr(PORT_CFG1_OFS, 16'h0015);
        idle(1);
        chk({advert_all_abilities, duplex_select, speed_select,
            autoneg_enable, pause_ability_enable}, 32'h0000_0222);
        clk_en <= 1'b0;
        wr(P0_IN_LIMIT_OFS, 16'h8001);
        clk_en <= 1'b1;
        rd(P0_IN_LIMIT_OFS, 16'h0000);
        do_reset();
        // The last read is compared one edge after it is taken
        idle(2);
        end_of_test();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #20_000;
        n_mismatch++;
        end_of_test();
    end
endmodule
